//--- design/fbod_defines.vh
// Constants for the flash bus host controller
`ifndef FBOD_DEFINES_VH
`define FBOD_DEFINES_VH
// Bus timing in ns, at 5 ns clock period
`define FBOD_CLK_PERIOD_NS 5
`define FBOD_GLITCH_NS 5
`define FBOD_IDLE_STANDBY_NS 150
`define FBOD_SETUP_NS 20
`define FBOD_PULSE_NS 45
`define FBOD_HOLD_NS 20
// Least times round up to whole cycles
`define FBOD_CYC(ns) (((ns) + `FBOD_CLK_PERIOD_NS - 1) / `FBOD_CLK_PERIOD_NS)
`define FBOD_SETUP_CYC `FBOD_CYC(`FBOD_SETUP_NS)
`define FBOD_PULSE_CYC `FBOD_CYC(`FBOD_PULSE_NS)
`define FBOD_HOLD_CYC `FBOD_CYC(`FBOD_HOLD_NS)
`define FBOD_IDLE_CYC `FBOD_CYC(`FBOD_IDLE_STANDBY_NS)
`define FBOD_CNT_W 8
`define FBOD_RST_WAIT_CYC 4
// Signature address bits
`define FBOD_SIG_A0 0
`define FBOD_SIG_A1 1
// Host state codes
`define FBOD_ST_WAIT_RDY 3'h0
`define FBOD_ST_IDLE 3'h1
`define FBOD_ST_SETUP 3'h2
`define FBOD_ST_PULSE 3'h3
`define FBOD_ST_HOLD 3'h4
`endif

//--- design/fbod_host.v
// Host controller that drives a parallel boot-block flash through its pins
//
// Summary of operation
// - No bus access after reset until ready line released
// - Shared ready low means some device busy
// - Read: enable and output low, write high
// - Output enable high during whole write
`timescale 1ns/1ps
`default_nettype none
`include "fbod_defines.vh"
module fbod_host #(
  parameter ADDR_W = 18
) (
  input wire clock_in,
  input wire rstn_in,
  input wire req_valid_in,
  output wire req_ready_out,
  input wire req_write_in,
  input wire req_word_in,
  input wire req_sig_in,
  input wire [ADDR_W:0] req_addr_in,
  input wire [15:0] req_wdata_in,
  output reg rsp_valid_out,
  output reg [15:0] rsp_rdata_out,
  output wire flash_busy_out,
  output reg flash_reset_n_out,
  output reg [ADDR_W-1:0] flash_addr_out,
  output reg flash_ce_n_out,
  output reg flash_oe_n_out,
  output reg flash_we_n_out,
  output reg flash_byte_n_out,
  output reg signature_select_line_out,
  input wire [15:0] flash_data_in,
  output reg [15:0] flash_data_out,
  output reg [15:0] flash_data_oe_out,
  input wire ready_busy_n_in
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  reg rb_meta_reg;
  reg rb_sync_reg;
  reg [15:0] din_meta_reg;
  reg [15:0] din_sync_reg;
  // Only the second flop of each pair is read by any logic
  // Data pins arrive two cycles late, so the read pulse is stretched to match
  always @(posedge clock_in)
  begin
    rb_meta_reg <= ready_busy_n_in;
    rb_sync_reg <= rb_meta_reg;
    din_meta_reg <= flash_data_in;
    din_sync_reg <= din_meta_reg;
  end
  // Low on the shared line means at least one part is busy
  assign flash_busy_out = ~rb_sync_reg;
  // ------------------------------------------------------------
  // Bus sequencer
  // ------------------------------------------------------------
  reg [2:0] state_reg;
  reg [`FBOD_CNT_W-1:0] cnt_reg;
  reg wr_reg;
  reg word_reg;
  wire rst_wait_done;
  // Two extra pulse cycles cover the data pin synchroniser
  localparam PULSE_LEN = `FBOD_PULSE_CYC + 2;
  assign req_ready_out = (state_reg == `FBOD_ST_IDLE);
  // ------------------------------------------------------------
  // Reset wait
  // ------------------------------------------------------------
  // The ready line is trusted only after the flash had time to pull it low
  assign rst_wait_done = (cnt_reg >= `FBOD_RST_WAIT_CYC);
  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  // True on the last cycle of a phase that lasts len cycles
  // One extra bit keeps the increment from wrapping
  function phase_end;
    input [`FBOD_CNT_W-1:0] cnt;
    input integer len;
    begin
      phase_end = ({1'b0, cnt} + 9'h001) >= len;
    end
  endfunction
  // Per-pin enables; in byte mode the top pin carries the byte address
  function [15:0] lane_oe;
    input wr;
    input word;
    begin
      if (wr)
        lane_oe = word ? 16'hffff : 16'h80ff;
      else
        lane_oe = word ? 16'h0000 : 16'h8000;
    end
  endfunction
  always @(posedge clock_in)
  begin
    if (!rstn_in)
    begin
      state_reg <= `FBOD_ST_WAIT_RDY;
      cnt_reg <= {`FBOD_CNT_W{1'b0}};
      wr_reg <= 1'b0;
      word_reg <= 1'b1;
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= 16'h0000;
      flash_reset_n_out <= 1'b0;
      flash_addr_out <= {ADDR_W{1'b0}};
      flash_ce_n_out <= 1'b1;
      flash_oe_n_out <= 1'b1;
      flash_we_n_out <= 1'b1;
      flash_byte_n_out <= 1'b1;
      signature_select_line_out <= 1'b0;
      flash_data_out <= 16'h0000;
      flash_data_oe_out <= 16'h0000;
    end
    else
    begin
      flash_reset_n_out <= 1'b1;
      rsp_valid_out <= 1'b0;
      case (state_reg)
        `FBOD_ST_WAIT_RDY:
        begin
          // Wait out the busy-after-reset period plus sync delay
          // Count first, then trust the synchronised ready level
          if (!rst_wait_done)
            cnt_reg <= cnt_reg + 8'h01;
          else if (rb_sync_reg)
            state_reg <= `FBOD_ST_IDLE;
        end
        `FBOD_ST_IDLE:
        begin
          // Strobes idle high: the flash drops into standby by itself
          flash_ce_n_out <= 1'b1;
          flash_oe_n_out <= 1'b1;
          flash_we_n_out <= 1'b1;
          flash_data_oe_out <= 16'h0000;
          if (req_valid_in)
          begin
            wr_reg <= req_write_in;
            word_reg <= req_word_in;
            flash_byte_n_out <= req_word_in;
            // Elevated select never rises on a write
            signature_select_line_out <= req_sig_in & ~req_write_in;
            flash_addr_out <= req_word_in ? req_addr_in[ADDR_W-1:0] :
              req_addr_in[ADDR_W:1];
            flash_data_out <= req_word_in ? req_wdata_in :
              {req_addr_in[0], 7'h00, req_wdata_in[7:0]};
            // Top pin always driven in byte mode, it carries the byte address
            flash_data_oe_out <= lane_oe(req_write_in, req_word_in);
            flash_ce_n_out <= 1'b0;
            cnt_reg <= {`FBOD_CNT_W{1'b0}};
            state_reg <= `FBOD_ST_SETUP;
          end
        end
        `FBOD_ST_SETUP:
        begin
          // Address settles before the strobe falls; flash latches it there
          if (phase_end(cnt_reg, `FBOD_SETUP_CYC))
          begin
            cnt_reg <= {`FBOD_CNT_W{1'b0}};
            if (wr_reg)
              flash_we_n_out <= 1'b0;
            else
              flash_oe_n_out <= 1'b0;
            state_reg <= `FBOD_ST_PULSE;
          end
          else
            cnt_reg <= cnt_reg + 8'h01;
        end
        `FBOD_ST_PULSE:
        begin
          // Pulse far longer than the flash glitch filter
          // Address and data stay still for the whole pulse
          if (phase_end(cnt_reg, PULSE_LEN))
          begin
            cnt_reg <= {`FBOD_CNT_W{1'b0}};
            flash_we_n_out <= 1'b1;
            flash_oe_n_out <= 1'b1;
            if (!wr_reg)
            begin
              rsp_valid_out <= 1'b1;
              rsp_rdata_out <= word_reg ? din_sync_reg : {8'h00, din_sync_reg[7:0]};
            end
            state_reg <= `FBOD_ST_HOLD;
          end
          else
            cnt_reg <= cnt_reg + 8'h01;
          flash_oe_n_out <= wr_reg | phase_end(cnt_reg, PULSE_LEN);
        end
        `FBOD_ST_HOLD:
        begin
          // Data stays driven through hold so the flash latches a settled word
          if (phase_end(cnt_reg, `FBOD_HOLD_CYC))
          begin
            flash_ce_n_out <= 1'b1;
            flash_data_oe_out <= 16'h0000;
            signature_select_line_out <= 1'b0;
            state_reg <= `FBOD_ST_IDLE;
          end
          else
            cnt_reg <= cnt_reg + 8'h01;
        end
        default:
          state_reg <= `FBOD_ST_WAIT_RDY;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- test/fbod_checker.sv
// Pin protocol checker for the flash host
`timescale 1ns/1ps
`default_nettype none
module fbod_chk (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic req_ready_out,
  input wire logic rsp_valid_out,
  input wire logic flash_reset_n_out,
  input wire logic flash_ce_n_out,
  input wire logic flash_oe_n_out,
  input wire logic flash_we_n_out,
  input wire logic [15:0] flash_data_out,
  input wire logic [15:0] flash_data_oe_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  sequence s_wlow; !flash_we_n_out [*8]; endsequence
  property p_rd; !flash_oe_n_out |-> !flash_ce_n_out && flash_we_n_out; endproperty
  a_rd: assert property (p_rd) else $error("bad read");
  property p_wr; !flash_we_n_out |-> flash_oe_n_out && !flash_ce_n_out; endproperty
  a_wr: assert property (p_wr) else $error("bad write");
  property p_oe; flash_data_oe_out[14:0] != 0 |-> flash_oe_n_out; endproperty
  a_oe: assert property (p_oe) else $error("contention");
  property p_ce; flash_ce_n_out |-> flash_data_oe_out == 16'h0000 && flash_we_n_out; endproperty
  a_ce: assert property (p_ce) else $error("standby");
  property p_rdy; $rose(flash_reset_n_out) |-> !req_ready_out [*4]; endproperty
  a_rdy: assert property (p_rdy) else $error("early");
  property p_wp; $fell(flash_we_n_out) |-> s_wlow ##[1:6] flash_we_n_out; endproperty
  a_wp: assert property (p_wp) else $error("pulse");
  property p_dat;
    !flash_we_n_out && !$past(flash_we_n_out) |-> $stable(flash_data_out);
  endproperty
  a_dat: assert property (p_dat) else $error("data moved");
  property p_rsp; $fell(flash_oe_n_out) |-> ##[8:14] rsp_valid_out; endproperty
  a_rsp: assert property (p_rsp) else $error("no answer");
endmodule
bind fbod_host fbod_chk u_chk (.*);
`default_nettype wire

//--- test/fbod_flash_model.sv
// Flash device model
`timescale 1ns/1ps
`default_nettype none
module fbod_flash_model #(
  parameter MFR = 16'h00a1, // Arbitrary code
  parameter DEV = 16'h00b2 // Arbitrary code
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [17:0] addr_in,
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic byte_n_in,
  input wire logic sig_in,
  input wire logic [15:0] hd_in,
  input wire logic [15:0] hoe_in,
  output logic [15:0] bus_out,
  output logic rb_n_out
);
  logic [7:0] busy_reg = 0;
  logic [15:0] last_reg = 0, cap_d, fd, drv, val;
  logic [17:0] cap_a;
  // Supply and protection are healthy unless the bench says otherwise
  logic lock_low = 1'b0;
  logic [7:0] prot_reg = 8'h00;
  logic wr_ok;
  assign wr_ok = !lock_low && !prot_reg[addr_in[17:15]];
  assign fd = sig_in ? (addr_in[0] ? DEV : MFR) : addr_in[15:0] ^ 16'h5a3c;
  assign drv = {{8{byte_n_in}}, 8'hff} & {16{!ce_n_in && !oe_n_in && we_n_in}};
  assign val = byte_n_in ? fd : {8'h00, hd_in[15] && !sig_in ? fd[15:8] : fd[7:0]};
  // Released lines flip each cycle so a stale level is never read back
  assign bus_out = hoe_in & hd_in | ~hoe_in & (drv & val | ~drv & ~last_reg);
  assign rb_n_out = busy_reg == 8'h00;
  always @(posedge clock_in)
  begin
    last_reg <= bus_out;
    if (!reset_n_in) busy_reg <= 8'h06;
    else if (!ce_n_in && !we_n_in && wr_ok) busy_reg <= 8'h10;
    else if (busy_reg != 8'h00) busy_reg <= busy_reg - 8'h01;
  end
  always @(negedge we_n_in) if (!ce_n_in) cap_a <= addr_in;
  always @(posedge we_n_in) if (!ce_n_in) cap_d <= bus_out;
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock_in = 0, rstn_in = 0, req_valid_in = 0, req_write_in = 0, req_word_in = 0;
  logic req_sig_in = 0, rsp_valid_out, req_ready_out, flash_busy_out, flash_reset_n_out;
  logic flash_ce_n_out, flash_oe_n_out, flash_we_n_out, flash_byte_n_out, ready_busy_n_in;
  logic signature_select_line_out;
  logic [18:0] req_addr_in = 0;
  logic [17:0] flash_addr_out;
  logic [15:0] req_wdata_in = 0, rsp_rdata_out, flash_data_out, flash_data_oe_out, flash_data_in;
  integer seed = 32'hc156b8cb, bad_count = 0, num_checks = 0, cyc = 0, i, n, r;
  fbod_host dut (.*);
  fbod_flash_model u_flash (.clock_in, .reset_n_in(flash_reset_n_out), .addr_in(flash_addr_out),
    .ce_n_in(flash_ce_n_out), .oe_n_in(flash_oe_n_out), .we_n_in(flash_we_n_out),
    .byte_n_in(flash_byte_n_out), .sig_in(signature_select_line_out), .hd_in(flash_data_out),
    .hoe_in(flash_data_oe_out), .bus_out(flash_data_in), .rb_n_out(ready_busy_n_in));
  task test_done;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input logic [18:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("FAIL %s exp %h got %h", nm, e, s);
    end
  endtask
  function logic [15:0] f_exp(input logic w, sg, input logic [18:0] a);
    logic [17:0] fa;
    logic [15:0] v;
    fa = w ? a[17:0] : a[18:1];
    v = sg ? (fa[0] ? u_flash.DEV : u_flash.MFR) : fa[15:0] ^ 16'h5a3c;
    f_exp = w ? v : {8'h00, a[0] && !sg ? v[15:8] : v[7:0]};
  endfunction
  task op(input logic w, wd, sg, input logic [18:0] a, input logic [15:0] d);
    {req_valid_in, req_write_in, req_word_in, req_sig_in, req_addr_in, req_wdata_in} = {1'b1, w, wd, sg, a, d};
    for (n = 0; n < 99 && req_ready_out !== 1; n++) @(posedge clock_in) #1;
    @(posedge clock_in) #1 req_valid_in = 0;
    repeat (2) @(posedge clock_in);
    #1 chk("byte_n", flash_byte_n_out, wd);
    for (n = 0; n < 99 && (w ? req_ready_out : rsp_valid_out) !== 1; n++) @(posedge clock_in) #1;
    if (!w) chk("rdata", rsp_rdata_out, f_exp(wd, sg, a));
    if (w) chk("addr", u_flash.cap_a, wd ? a[17:0] : a[18:1]);
    if (w) chk("data", u_flash.cap_d & (wd ? 16'hffff : 16'h80ff), wd ? d : {a[0], 7'h0, d[7:0]});
  endtask
  initial forever #2.5 clock_in = ~clock_in;
  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      bad_count++;
      test_done;
    end
  end
  initial
  begin
    repeat (8) @(posedge clock_in);
    #1 rstn_in = 1;
    for (n = 0; n < 99 && req_ready_out !== 1; n++) @(posedge clock_in) #1;
    chk("rb_n", ready_busy_n_in, 1);
    for (i = 0; i < 4; i++) op(0, i[1], 1, i[1] ? i[0] : 2 * i[0], 0);
    op(1, 0, 0, 19'h7ffff, 16'hffa5);
    repeat (3) @(posedge clock_in);
    #1 chk("busy", flash_busy_out, 1);
    repeat (20) @(posedge clock_in);
    #1 chk("busy", flash_busy_out, 0);
    u_flash.lock_low = 1;
    op(1, 1, 0, 19'h00100, 16'h1234);
    repeat (3) @(posedge clock_in);
    #1 chk("lockout", flash_busy_out, 0);
    u_flash.lock_low = 0;
    u_flash.prot_reg = 8'h01;
    op(1, 1, 0, 19'h00100, 16'h1234);
    repeat (3) @(posedge clock_in);
    #1 chk("protect", flash_busy_out, 0);
    u_flash.prot_reg = 8'h00;
    for (i = 0; i < 40; i++)
    begin
      r = $random(seed);
      op(r[0], r[1], 0, r[20:2], r[31:16]);
    end
    test_done;
  end
endmodule
`default_nettype wire
